// file: nand_feat_pkg.sv
// shared constants for the serial nand program/erase/feature block
package nand_feat_pkg;
	// opcodes
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_LOAD = 8'h02;
	localparam logic [7:0] OP_LOAD_X4 = 8'h32;
	localparam logic [7:0] OP_LOAD_RAND = 8'h84;
	localparam logic [7:0] OP_LOAD_RAND_X4 = 8'h34;
	localparam logic [7:0] OP_EXECUTE = 8'h10;
	localparam logic [7:0] OP_ERASE = 8'hD8;
	localparam logic [7:0] OP_GET_FEAT = 8'h0F;
	localparam logic [7:0] OP_SET_FEAT = 8'h1F;
	localparam logic [7:0] OP_RESET = 8'hFF;
	// feature addresses
	localparam logic [7:0] FA_PROTECT = 8'hA0;
	localparam logic [7:0] FA_CONFIG = 8'hB0;
	localparam logic [7:0] FA_STATUS = 8'hC0;
	localparam logic [7:0] FA_DIE = 8'hD0;
	// block_protection_control fields
	localparam int PROT_WR_DISABLE_BIT = 7;
	localparam int PROT_RANGE_LSB = 3;
	localparam int PROT_TB_BIT = 2;
	localparam int PROT_HOLD_DIS_BIT = 1;
	localparam logic [7:0] PROT_RESET = 8'h7C;
	localparam logic [7:0] PROT_WMASK = 8'hFE;
	localparam logic [7:0] PROT_FREEZE_MASK = 8'hFC;
	// device_configuration fields
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CFG_WMASK = 8'hF2;
	localparam logic [7:0] CFG_MODE_MASK = 8'hC2;
	// die_selection fields
	localparam logic [7:0] DIE_RESET = 8'h00;
	localparam logic [7:0] DIE_WMASK = 8'h40;
	// frame layout, in serial bits: opcode from frame start, addresses after the opcode
	localparam logic [4:0] OPC_LAST = 5'd7;
	localparam logic [4:0] COL_ADDR_LAST = 5'd15;
	localparam logic [4:0] ROW_ADDR_LAST = 5'd23;
	localparam logic [4:0] FEAT_ADDR_LAST = 5'd7;
	// array geometry
	localparam int CACHE_BYTES = 2176;
	localparam int BLOCK_COUNT = 2048;
	localparam int PAGE_BITS = 6;
	localparam int BLOCK_BITS = 11;
	// busy times
	localparam int MCLK_MHZ = 250;
	localparam int PROG_BUSY_US = 600;
	localparam int ERASE_BUSY_US = 10000;
	localparam int PROG_BUSY_CYCLES = PROG_BUSY_US * MCLK_MHZ;
	localparam int ERASE_BUSY_CYCLES = ERASE_BUSY_US * MCLK_MHZ;
	localparam int TIMER_W = 22;
endpackage

// file: pin_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync import nand_feat_pkg::*; #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// pins in, synchronised out
	input wire logic [W-1:0] pin,
	output logic [W-1:0] sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sync_s;
	sync_s r_q, r_d;

	always_comb begin
		r_d.meta = pin;
		r_d.sync = r_q.meta;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r_q <= {INIT, INIT};
		end else begin
			r_q <= r_d;
		end
	end

	assign sync = r_q.sync;
endmodule

// file: skid_buffer.sv
// two-entry buffer, registered output, registered ready
`timescale 1ns/1ps
module skid_buffer import nand_feat_pkg::*; #(
	parameter int WIDTH = 20
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	typedef struct packed {
		logic out_valid;
		logic [WIDTH-1:0] out_data;
		logic skid_valid;
		logic [WIDTH-1:0] skid_data;
	} buf_s;
	buf_s r_q, r_d;

	always_comb begin
		r_d = r_q;
		if (out_ready || !r_q.out_valid) begin
			if (r_q.skid_valid) begin
				r_d.out_valid = 1'b1;
				r_d.out_data = r_q.skid_data;
				r_d.skid_valid = 1'b0;
			end else begin
				r_d.out_valid = in_valid;
				r_d.out_data = in_data;
			end
		end else if (in_valid && !r_q.skid_valid) begin
			// second entry holds the word the stalled receiver could not take
			r_d.skid_valid = 1'b1;
			r_d.skid_data = in_data;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign in_ready = !r_q.skid_valid;
	assign out_valid = r_q.out_valid;
	assign out_data = r_q.out_data;
endmodule

// file: nand_prog_erase.sv
// serial nand command sequencer: program, erase, feature registers
`timescale 1ns/1ps
module nand_prog_erase import nand_feat_pkg::*; #(
	parameter int PROG_CYCLES = PROG_BUSY_CYCLES,
	parameter int ERASE_CYCLES = ERASE_BUSY_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// serial link pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	input wire logic wp_n,
	// array write stream
	output logic arr_wr_valid,
	output logic [11:0] arr_wr_col,
	output logic [7:0] arr_wr_data,
	input wire logic arr_wr_ready,
	output logic [23:0] arr_row,
	// array erase
	output logic erase_start,
	output logic [BLOCK_BITS-1:0] erase_block
);
	typedef enum logic [5:0] {
		F_IDLE = 6'b000001,
		F_OPC = 6'b000010,
		F_ADDR = 6'b000100,
		F_DATA = 6'b001000,
		F_OUT = 6'b010000,
		F_SKIP = 6'b100000
	} frame_e;

	typedef struct packed {
		frame_e st;
		logic sclk_prev;
		logic [4:0] bitcnt;
		logic [4:0] alen;
		logic [7:0] opc;
		logic [23:0] sh;
		logic [11:0] col;
		logic [7:0] faddr;
		logic [2:0] ocnt;
		logic [7:0] obyte;
		logic so;
		logic oe_n;
		logic [7:0] prot;
		logic [7:0] cfg;
		logic [7:0] die;
		logic write_enable_latch;
		logic operation_in_progress;
		logic efail;
		logic pfail;
		logic [TIMER_W-1:0] timer;
		logic streaming;
		logic [11:0] idx;
		logic [23:0] row;
		logic erase;
		logic [BLOCK_BITS-1:0] eblk;
	} core_s;
	core_s r_q, r_d;

	logic sclk_s, cs_n_s, wp_n_s;
	logic [3:0] io_s;
	logic buf_in_ready;
	logic clr_fill, wr_cache;
	logic [7:0] wr_byte;
	logic [CACHE_BYTES-1:0] fill_q;
	logic [7:0] cache_mem [CACHE_BYTES];

	pin_sync #(.W(7), .INIT(7'h02)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.pin({io_in, wp_n, cs_n, sclk}),
		.sync({io_s, wp_n_s, cs_n_s, sclk_s})
	);

	// unfilled cache bytes read as erased
	function automatic logic [7:0] cache_byte(input logic [11:0] a);
		cache_byte = fill_q[a] ? cache_mem[a] : 8'hFF;
	endfunction

	function automatic logic [7:0] feature(input logic [7:0] fa, input core_s s);
		case (fa)
			FA_PROTECT: feature = s.prot;
			FA_CONFIG: feature = s.cfg;
			FA_STATUS: feature = {4'h0, s.pfail, s.efail, s.write_enable_latch, s.operation_in_progress};
			FA_DIE: feature = s.die;
			default: feature = 8'h00;
		endcase
	endfunction

	function automatic logic is_locked(input logic [23:0] row, input logic [7:0] prot);
		logic [BLOCK_BITS-1:0] blk;
		logic [3:0] rng;
		logic [11:0] n;
		blk = row[PAGE_BITS +: BLOCK_BITS];
		rng = prot[PROT_RANGE_LSB +: 4];
		n = 12'h001 << rng;
		if (rng == 4'h0) begin
			is_locked = 1'b0;
		end else if (rng > 4'hA) begin
			is_locked = 1'b1;
		end else if (prot[PROT_TB_BIT]) begin
			is_locked = {1'b0, blk} < n;
		end else begin
			is_locked = {1'b0, blk} >= 12'(BLOCK_COUNT) - n;
		end
	endfunction

	logic rise, fall, quad;
	logic [23:0] sh_in;
	logic [7:0] byte_in;

	always_comb begin
		r_d = r_q;
		clr_fill = 1'b0;
		wr_cache = 1'b0;
		rise = sclk_s && !r_q.sclk_prev;
		fall = !sclk_s && r_q.sclk_prev;
		quad = (r_q.opc == OP_LOAD_X4) || (r_q.opc == OP_LOAD_RAND_X4);
		sh_in = (r_q.st == F_DATA && quad) ? {r_q.sh[19:0], io_s} : {r_q.sh[22:0], io_s[0]};
		byte_in = sh_in[7:0];
		wr_byte = byte_in;
		r_d.sclk_prev = sclk_s;
		r_d.erase = 1'b0;

		// busy phase: stream the cache out while the busy timer counts down; done when both have finished
		if (r_q.streaming && buf_in_ready) begin
			if (r_q.idx == 12'(CACHE_BYTES - 1)) begin
				r_d.streaming = 1'b0;
			end else begin
				r_d.idx = r_q.idx + 12'h001;
			end
		end
		if (r_q.timer != '0) begin
			r_d.timer = r_q.timer - 1'b1;
		end else if (r_q.operation_in_progress && !r_q.streaming && !arr_wr_valid) begin
			r_d.operation_in_progress = 1'b0;
			r_d.write_enable_latch = 1'b0;
		end

		if (cs_n_s) begin
			// frame closes on chip select rising; loads end here
			r_d.st = F_IDLE;
			r_d.oe_n = 1'b1;
			r_d.bitcnt = '0;
		end else if (rise) begin
			r_d.sh = sh_in;
			r_d.bitcnt = r_q.bitcnt + ((r_q.st == F_DATA && quad) ? 5'd4 : 5'd1);
			case (r_q.st)
				F_IDLE, F_OPC: begin
					r_d.st = F_OPC;
					if (r_q.st == F_IDLE) begin
						r_d.bitcnt = 5'd1;
					end
					if (r_q.st == F_OPC && r_q.bitcnt == OPC_LAST) begin
						r_d.opc = byte_in;
						r_d.bitcnt = '0;
						r_d.st = F_SKIP;
						case (byte_in)
							OP_WR_ENABLE: if (!r_d.operation_in_progress) r_d.write_enable_latch = 1'b1;
							OP_WR_DISABLE: if (!r_d.operation_in_progress) r_d.write_enable_latch = 1'b0;
							OP_RESET: r_d.cfg = r_q.cfg & ~CFG_MODE_MASK;
							OP_LOAD, OP_LOAD_X4, OP_LOAD_RAND, OP_LOAD_RAND_X4: begin
								if (!r_q.operation_in_progress) begin
									r_d.st = F_ADDR;
									r_d.alen = COL_ADDR_LAST;
								end
							end
							OP_EXECUTE, OP_ERASE: begin
								if (!r_q.operation_in_progress) begin
									r_d.st = F_ADDR;
									r_d.alen = ROW_ADDR_LAST;
								end
							end
							OP_GET_FEAT, OP_SET_FEAT: begin
								r_d.st = F_ADDR;
								r_d.alen = FEAT_ADDR_LAST;
							end
							default: r_d.st = F_SKIP;
						endcase
					end
				end
				F_ADDR: begin
					if (r_q.bitcnt == r_q.alen) begin
						r_d.bitcnt = '0;
						r_d.st = F_SKIP;
						case (r_q.opc)
							OP_LOAD, OP_LOAD_X4, OP_LOAD_RAND, OP_LOAD_RAND_X4: begin
								r_d.col = sh_in[11:0];
								r_d.st = F_DATA;
								clr_fill = (r_q.opc == OP_LOAD) || (r_q.opc == OP_LOAD_X4);
							end
							OP_EXECUTE: begin
								if (r_q.write_enable_latch) begin
									r_d.row = sh_in;
									if (is_locked(sh_in, r_q.prot)) begin
										r_d.pfail = 1'b1;
										r_d.write_enable_latch = 1'b0;
									end else begin
										r_d.pfail = 1'b0;
										r_d.operation_in_progress = 1'b1;
										r_d.streaming = 1'b1;
										r_d.idx = '0;
										r_d.timer = TIMER_W'(PROG_CYCLES);
									end
								end
							end
							OP_ERASE: begin
								if (r_q.write_enable_latch) begin
									if (is_locked(sh_in, r_q.prot)) begin
										r_d.efail = 1'b1;
										r_d.write_enable_latch = 1'b0;
									end else begin
										r_d.efail = 1'b0;
										r_d.operation_in_progress = 1'b1;
										r_d.erase = 1'b1;
										r_d.eblk = sh_in[PAGE_BITS +: BLOCK_BITS];
										r_d.timer = TIMER_W'(ERASE_CYCLES);
									end
								end
							end
							OP_GET_FEAT: begin
								r_d.faddr = byte_in;
								r_d.obyte = feature(byte_in, r_q);
								r_d.ocnt = '0;
								r_d.st = F_OUT;
							end
							default: begin
								r_d.faddr = byte_in;
								r_d.st = F_DATA;
							end
						endcase
					end
				end
				F_DATA: begin
					if (r_q.opc == OP_SET_FEAT) begin
						if (r_q.bitcnt == 5'd7) begin
							r_d.st = F_SKIP;
							case (r_q.faddr)
								FA_PROTECT: begin
									if (!r_q.prot[PROT_HOLD_DIS_BIT] && r_q.prot[PROT_WR_DISABLE_BIT] && !wp_n_s) begin
										// range bits frozen, only hold-disable may change
										r_d.prot = (r_q.prot & PROT_FREEZE_MASK) | (byte_in & ~PROT_FREEZE_MASK & PROT_WMASK);
									end else begin
										r_d.prot = byte_in & PROT_WMASK;
									end
								end
								FA_CONFIG: r_d.cfg = byte_in & CFG_WMASK;
								FA_DIE: r_d.die = byte_in & DIE_WMASK;
								default: r_d.st = F_SKIP;
							endcase
						end
					end else if ((quad && r_q.bitcnt[2:0] == 3'd4) || (!quad && r_q.bitcnt[2:0] == 3'd7)) begin
						r_d.bitcnt = '0;
						wr_cache = r_q.col < 12'(CACHE_BYTES);
						if (r_q.col != 12'hFFF) begin
							r_d.col = r_q.col + 12'h001;
						end
					end
				end
				default: r_d.st = r_q.st;
			endcase
		end else if (fall && r_q.st == F_OUT) begin
			// shift the selected feature out msb first; refresh each byte so polling sees busy drop
			r_d.so = r_q.obyte[~r_q.ocnt];
			r_d.oe_n = 1'b0;
			r_d.ocnt = r_q.ocnt + 3'd1;
			if (r_q.ocnt == 3'd7) begin
				r_d.obyte = feature(r_q.faddr, r_q);
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r_q <= '0;
			r_q.st <= F_IDLE;
			r_q.sclk_prev <= 1'b0;
			r_q.oe_n <= 1'b1;
			r_q.prot <= PROT_RESET;
			r_q.cfg <= CFG_RESET;
			r_q.die <= DIE_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// cache storage kept out of the state record; no reset, fill flags mark valid bytes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fill_q <= '0;
		end else if (clr_fill) begin
			fill_q <= '0;
		end else if (wr_cache) begin
			fill_q[r_q.col] <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (wr_cache) begin
			cache_mem[r_q.col] <= wr_byte;
		end
	end

	skid_buffer #(.WIDTH(20)) u_buf (
		.mclk(mclk),
		.reset(reset),
		.in_valid(r_q.streaming),
		.in_data({r_q.idx, cache_byte(r_q.idx)}),
		.in_ready(buf_in_ready),
		.out_valid(arr_wr_valid),
		.out_data({arr_wr_col, arr_wr_data}),
		.out_ready(arr_wr_ready)
	);

	assign io_out = {2'b00, r_q.so, 1'b0};
	assign io_oe_n = {2'b11, r_q.oe_n, 1'b1};
	assign arr_row = r_q.row;
	assign erase_start = r_q.erase;
	assign erase_block = r_q.eblk;
endmodule

// file: nand_prog_erase_sva.sv
// port checker for the nand sequencer
`timescale 1ns/1ps
module nand_prog_erase_sva import nand_feat_pkg::*; #(
	parameter int PROG_CYCLES = 1,
	parameter int ERASE_CYCLES = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// serial pins
	input wire logic cs_n,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n,
	// array side
	input wire logic arr_wr_valid,
	input wire logic [11:0] arr_wr_col,
	input wire logic [7:0] arr_wr_data,
	input wire logic arr_wr_ready,
	input wire logic [23:0] arr_row,
	input wire logic erase_start
);
	logic seen_q;
	logic [11:0] col_q;
	// last column taken, so stalls and gaps cannot hide a skipped word
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			seen_q <= 1'b0;
			col_q <= 12'h000;
		end else if (arr_wr_valid && arr_wr_ready) begin
			seen_q <= arr_wr_col != 12'(CACHE_BYTES - 1);
			col_q <= arr_wr_col;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	sequence s_stall;
		arr_wr_valid && !arr_wr_ready;
	endsequence
	sequence s_held;
		arr_wr_valid && $stable(arr_wr_col) && $stable(arr_wr_data);
	endsequence
	a_pins_idle: assert property (io_oe_n[3:2] == 2'b11 && io_oe_n[0] && io_out[3:2] == 2'b00 && !io_out[0])
		else $error("unused pin driven");
	a_oe_framed: assert property (!io_oe_n[1] |-> !$past(cs_n, 8)) else $error("drive outside frame");
	a_oe_release: assert property ($rose(cs_n) |-> ##[1:8] io_oe_n[1]) else $error("drive not released");
	a_stream_hold: assert property (s_stall |=> s_held) else $error("word changed in stall");
	a_col_order: assert property (arr_wr_valid |-> arr_wr_col == (seen_q ? col_q + 12'd1 : 12'd0))
		else $error("column out of order");
	a_row_stable: assert property (arr_wr_valid && $past(arr_wr_valid) |-> $stable(arr_row))
		else $error("row moved in stream");
	a_erase_pulse: assert property (erase_start |=> !erase_start) else $error("erase pulse long");
	a_erase_alone: assert property (erase_start |-> !arr_wr_valid) else $error("erase during stream");
endmodule
bind nand_prog_erase nand_prog_erase_sva #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) sva_i (
	.mclk(mclk), .reset(reset), .cs_n(cs_n), .io_out(io_out), .io_oe_n(io_oe_n), .arr_wr_valid(arr_wr_valid),
	.arr_wr_col(arr_wr_col), .arr_wr_data(arr_wr_data), .arr_wr_ready(arr_wr_ready), .arr_row(arr_row),
	.erase_start(erase_start));

// file: host.sv
// serial host model framing commands on the link pins
`timescale 1ns/1ps
module host import nand_feat_pkg::*; (
	// clock
	input wire logic mclk,
	// link pins
	output logic sclk,
	output logic cs_n,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// link clock stands low between frames, 32 ns per clock period inside
	task automatic clk_out(input logic [3:0] d);
		sclk <= 1'b0;
		io_in <= d;
		tick(4);
		sclk <= 1'b1;
		tick(4);
	endtask
	task automatic send(input logic [31:0] d, input int n);
		for (int i = n - 1; i >= 0; i--) clk_out({3'b000, d[i]});
	endtask
	task automatic start();
		@(posedge mclk);
		cs_n <= 1'b0;
		tick(4);
	endtask
	// frame closes only on chip select rise; lines then show a changed value
	task automatic stop();
		sclk <= 1'b0;
		tick(4);
		cs_n <= 1'b1;
		io_in <= ~io_in;
		tick(12);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int an, input int nb, input logic [7:0] d,
		input logic quad);
		logic [7:0] b;
		start();
		send(op, 8);
		send(a, an);
		for (int k = 0; k < nb; k++) begin
			b = d + 8'(k);
			if (quad) begin
				clk_out(b[7:4]);
				clk_out(b[3:0]);
			end else
				send(b, 8);
		end
		stop();
	endtask
	task automatic get(input logic [7:0] fa, output logic [7:0] v);
		start();
		send(OP_GET_FEAT, 8);
		send(fa, 8);
		for (int i = 7; i >= 0; i--) begin
			clk_out(4'h0);
			v[i] = io_oe_n[1] ? ~io_out[1] : io_out[1];
		end
		stop();
	endtask
	task automatic poll(output logic [7:0] v);
		for (int n = 0; n < 100; n++) begin
			get(FA_STATUS, v);
			if (v[0] === 1'b0) break;
		end
	endtask
endmodule

// file: nand_prog_erase_bench.sv
// bench for the nand program/erase/feature sequencer
`timescale 1ns/1ps
module nand_prog_erase_bench import nand_feat_pkg::*; ;
	localparam int PC = 3000;
	localparam int EC = 50;
	typedef struct packed {logic [7:0] fa; logic [7:0] wr; logic [7:0] rd;} row_s;
	logic mclk, reset, sclk, cs_n, wp_n, arr_wr_ready, arr_wr_valid, erase_start;
	logic [3:0] io_in, io_out, io_oe_n;
	logic [11:0] arr_wr_col;
	logic [7:0] arr_wr_data, v;
	logic [23:0] arr_row;
	logic [BLOCK_BITS-1:0] erase_block, eb;
	logic [7:0] mem [CACHE_BYTES];
	int n_mismatch, checks_done, nw, ne, cyc;
	row_s rows [5] = '{'{FA_PROTECT, 8'hFF, 8'hFE}, '{FA_CONFIG, 8'hFF, 8'hF2}, '{FA_STATUS, 8'hFF, 8'h00},
		'{FA_DIE, 8'hFF, 8'h40}, '{FA_PROTECT, 8'h00, 8'h00}};
	nand_prog_erase #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) nand_prog_erase_i (.mclk(mclk), .reset(reset),
		.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .wp_n(wp_n),
		.arr_wr_valid(arr_wr_valid), .arr_wr_col(arr_wr_col), .arr_wr_data(arr_wr_data),
		.arr_wr_ready(arr_wr_ready), .arr_row(arr_row), .erase_start(erase_start), .erase_block(erase_block));
	host host_i (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// array sink stalls often and in long runs so the buffer fills
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		arr_wr_ready <= cyc[1:0] != 2'b00 && cyc[9:7] != 3'b111;
		if (arr_wr_valid && arr_wr_ready) begin
			mem[arr_wr_col] <= arr_wr_data;
			nw <= nw + 1;
		end
		if (erase_start) begin
			ne <= ne + 1;
			eb <= erase_block;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic setf(input logic [7:0] fa, input logic [7:0] d);
		host_i.cmd(OP_SET_FEAT, fa, 8, 1, d, 1'b0);
	endtask
	task automatic getf(input logic [7:0] fa, input logic [7:0] exp);
		host_i.get(fa, v);
		chk(v, exp);
	endtask
	task automatic op1(input logic [7:0] op);
		host_i.cmd(op, 0, 0, 0, 0, 1'b0);
	endtask
	// whole run needs some 16k cycles
	initial begin
		repeat (100000) @(posedge mclk);
		n_mismatch++;
		stop_test();
	end
	initial begin
		reset = 1'b1;
		wp_n = 1'b1;
		n_mismatch = 0;
		checks_done = 0;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		getf(FA_PROTECT, 8'h7C);
		getf(FA_STATUS, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			setf(rows[i].fa, rows[i].wr);
			getf(rows[i].fa, rows[i].rd);
		end
		$display("test features done");
		host_i.cmd(OP_ERASE, 32'h000140, 24, 0, 0, 1'b0);
		repeat (20) @(posedge mclk);
		chk(ne, 0);
		getf(FA_STATUS, 8'h00);
		op1(OP_WR_ENABLE);
		getf(FA_STATUS, 8'h02);
		host_i.cmd(OP_ERASE, 32'h000140, 24, 0, 0, 1'b0);
		host_i.poll(v);
		chk(v, 8'h00);
		chk(ne, 1);
		chk(eb, 11'd5);
		$display("test erase done");
		host_i.cmd(8'h13, 0, 24, 0, 0, 1'b0);
		op1(OP_WR_ENABLE);
		host_i.cmd(OP_LOAD, 32'h000A, 16, 3, 8'hA0, 1'b0);
		host_i.cmd(OP_LOAD_RAND_X4, 32'h000B, 16, 1, 8'h5B, 1'b1);
		host_i.cmd(OP_LOAD_RAND, 32'h087E, 16, 4, 8'hC0, 1'b0);
		host_i.cmd(OP_EXECUTE, 32'h000123, 24, 0, 0, 1'b0);
		getf(FA_STATUS, 8'h03);
		host_i.poll(v);
		chk(v, 8'h00);
		chk(nw, CACHE_BYTES);
		chk(arr_row, 24'h000123);
		chk(mem[0], 8'hFF);
		chk(mem[10], 8'hA0);
		chk(mem[11], 8'h5B);
		chk(mem[12], 8'hA2);
		chk(mem[2175], 8'hC1);
		$display("test program done");
		setf(FA_PROTECT, 8'h7C);
		op1(OP_WR_ENABLE);
		host_i.cmd(OP_EXECUTE, 32'h000123, 24, 0, 0, 1'b0);
		host_i.poll(v);
		chk(v, 8'h08);
		op1(OP_WR_ENABLE);
		host_i.cmd(OP_ERASE, 32'h000140, 24, 0, 0, 1'b0);
		host_i.poll(v);
		chk(v, 8'h0C);
		chk(nw, CACHE_BYTES);
		chk(ne, 1);
		$display("test lock done");
		setf(FA_PROTECT, 8'h80);
		wp_n <= 1'b0;
		setf(FA_PROTECT, 8'h02);
		getf(FA_PROTECT, 8'h82);
		wp_n <= 1'b1;
		setf(FA_CONFIG, 8'hF2);
		op1(OP_RESET);
		getf(FA_CONFIG, 8'h30);
		getf(FA_PROTECT, 8'h82);
		$display("test freeze and reset done");
		// latch cleared by the disable command; fail bits from the lock test remain
		op1(OP_WR_ENABLE);
		op1(OP_WR_DISABLE);
		getf(FA_STATUS, 8'h0C);
		op1(OP_WR_ENABLE);
		host_i.cmd(OP_LOAD_X4, 32'h0003, 16, 1, 8'h3C, 1'b1);
		host_i.cmd(OP_EXECUTE, 32'h000200, 24, 0, 0, 1'b0);
		host_i.poll(v);
		chk(v, 8'h04);
		chk(nw, 2 * CACHE_BYTES);
		chk(mem[3], 8'h3C);
		chk(mem[10], 8'hFF);
		chk(arr_row, 24'h000200);
		$display("test quad load done");
		stop_test();
	end
endmodule
